// file: emr_cfg.svh
// Register offsets, field positions, reset values and masks of the error message router
`ifndef EMR_CFG_SVH
`define EMR_CFG_SVH

// Register indices; byte address is four times the index
`define EMR_IDX_SERR_EN     12'h0ca
`define EMR_IDX_SMI_EN      12'h0cc
`define EMR_IDX_SCI_EN      12'h0ce
`define EMR_IDX_SCRATCH     12'h0de
`define EMR_IDX_PENDING     12'h0d0

// Reset values
`define EMR_RST_SERR_EN     16'h0000
`define EMR_RST_SMI_EN      16'h0000
`define EMR_RST_SCI_EN      16'h0000
`define EMR_RST_SCRATCH     16'h0000

// Implemented bits; all others are reserved
`define EMR_MASK_SERR_EN    16'h027f
`define EMR_MASK_SMI_EN     16'h0003
`define EMR_MASK_SCI_EN     16'h0003

// Field positions shared by the flags and the enables
`define EMR_BIT_SINGLE_ECC  0
`define EMR_BIT_MULTI_ECC   1
`define EMR_BIT_BAD_ENTRY   2
`define EMR_BIT_INVALID_AGP 3
`define EMR_BIT_OUT_APERT   4
`define EMR_BIT_UNIMPL_SC   5
`define EMR_BIT_TGT_ABORT   6
`define EMR_BIT_NONDRAM_LK  9

`endif

// file: emr_hub_link.sv
// Hub link receiver model taking error messages
`timescale 1ns/10ps
module emr_hub_link (
    // Clock, reset, stall mode
    input wire logic              CLK_SYS, NRST, SLOW,
    // Message channel
    input wire emr_pkg::emr_msg_t MSG,
    output logic                  MSG_READY
);
    // Random stalls when slow stretch back-to-back hand-overs; out of reset, ready is always high after an empty slot
    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST || !SLOW)
            MSG_READY <= NRST;
        else
            MSG_READY <= ($urandom_range(3) == 0) || !MSG.valid;
    end
endmodule // emr_hub_link

// file: emr_pkg.sv
// Types of the error message router
package emr_pkg;

    // Kind of error message sent on the hub link
    typedef enum logic [1:0] {
        EMR_KIND_SERR,
        EMR_KIND_SMI,
        EMR_KIND_SCI
    } emr_kind_t;

    // One message request toward the hub link
    typedef struct packed {
        logic      valid;
        emr_kind_t kind;
        logic [3:0] source;
    } emr_msg_t;

endpackage

// file: emr_router.sv
// Error message router: enable registers, scratchpad and hub link message requests
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "emr_cfg.svh"

module emr_router #(
    parameter int FLAG_W = 16  // Width of the error status flag vector
) (
    // Clock and reset
    input  wire logic              CLK_SYS,
    input  wire logic              NRST,
    // APB slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [11:0]       PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // Error status flags and global SERR enable from the host bridge
    input  wire logic [FLAG_W-1:0] ERR_FLAGS,
    input  wire logic              PCI_SERR_EN,
    // Message request toward the hub link
    output emr_pkg::emr_msg_t      MSG,
    input  wire logic              MSG_READY
);

    logic [15:0]             serr_enable_q;  // SERR enable register
    logic [15:0]             smi_enable_q;   // SMI enable register
    logic [15:0]             sci_enable_q;   // SCI enable register
    logic [15:0]             scratchpad_q;   // Scratchpad, no function
    logic [FLAG_W-1:0]       flags_prev_q;   // Flags one cycle ago
    logic [FLAG_W-1:0]       rise;           // Zero-to-one flag transitions
    logic [FLAG_W-1:0]       pend_q;         // Occurrences awaiting a message
    emr_pkg::emr_kind_t      kind_q [FLAG_W]; // Kind chosen at occurrence
    logic [FLAG_W-1:0]       take;           // One-hot pick being loaded
    logic                    load;           // Output slot free and work pending
    logic [3:0]              pick_idx;       // Index of lowest pending flag
    emr_pkg::emr_msg_t       msg_q;          // Registered message request
    logic                    wr_en;          // APB write strobe
    logic                    rd_hit;         // Address maps to a register
    logic [11:0]             idx;            // Word index from address, zero-extended

    // Registers answer in the access phase with no wait states
    assign PREADY = 1'b1;
    assign idx    = {2'b00, PADDR[11:2]};
    assign wr_en  = PSEL & PENABLE & PWRITE;
    assign MSG    = msg_q;

    // Address decode; anything else is refused with an error
    always_comb
    begin
        rd_hit = 1'b1;
        PRDATA = 32'h0000_0000;
        if (idx == `EMR_IDX_SERR_EN)
        begin
            PRDATA = {16'h0000, serr_enable_q};
        end
        else if (idx == `EMR_IDX_SMI_EN)
        begin
            PRDATA = {16'h0000, smi_enable_q};
        end
        else if (idx == `EMR_IDX_SCI_EN)
        begin
            PRDATA = {16'h0000, sci_enable_q};
        end
        else if (idx == `EMR_IDX_SCRATCH)
        begin
            PRDATA = {16'h0000, scratchpad_q};
        end
        else if (idx == `EMR_IDX_PENDING)
        begin
            // Live view of queued occurrences
            PRDATA = 32'(pend_q);
        end
        else
        begin
            rd_hit = 1'b0;
        end
    end

    // Error reply only at the completing edge of an unmapped access
    assign PSLVERR = PSEL & PENABLE & ~rd_hit;

    // Enable registers; reserved bits held at zero
    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
        begin
            serr_enable_q <= `EMR_RST_SERR_EN;
            smi_enable_q  <= `EMR_RST_SMI_EN;
            sci_enable_q  <= `EMR_RST_SCI_EN;
        end
        else if (wr_en)
        begin
            if (idx == `EMR_IDX_SERR_EN)
            begin
                serr_enable_q <= PWDATA[15:0] & `EMR_MASK_SERR_EN;
            end
            else if (idx == `EMR_IDX_SMI_EN)
            begin
                smi_enable_q <= PWDATA[15:0] & `EMR_MASK_SMI_EN;
            end
            else if (idx == `EMR_IDX_SCI_EN)
            begin
                sci_enable_q <= PWDATA[15:0] & `EMR_MASK_SCI_EN;
            end
        end
    end

    // Scratchpad: storage only, read by nothing but the bus
    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
        begin
            scratchpad_q <= `EMR_RST_SCRATCH;
        end
        else if (wr_en && idx == `EMR_IDX_SCRATCH)
        begin
            scratchpad_q <= PWDATA[15:0];
        end
    end

    // Flag history for edge detection; flags come from same-clock logic
    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
        begin
            flags_prev_q <= '0;
        end
        else
        begin
            flags_prev_q <= ERR_FLAGS;
        end
    end

    // Flags are inputs, set outside regardless of enables
    assign rise = ERR_FLAGS & ~flags_prev_q;

    // Lowest pending flag wins the output slot
    always_comb
    begin
        pick_idx = 4'h0;
        take     = '0;
        for (int i = FLAG_W - 1; i >= 0; i--)
        begin
            if (pend_q[i])
            begin
                pick_idx = 4'(i);
            end
        end
        load = (!msg_q.valid || MSG_READY) && (pend_q != '0);
        if (load)
        begin
            take[pick_idx] = 1'b1;
        end
    end

    // Per-flag pending bit: one entry per flag, one kind per entry; a repeat occurrence while pending merges and overwrites the kind
    for (genvar g = 0; g < FLAG_W; g++)
    begin : g_flag
        logic serr_ok;  // SERR path open for this flag
        // Global SERR enable gates every SERR
        assign serr_ok = serr_enable_q[g] & PCI_SERR_EN;

        always_ff @(posedge CLK_SYS)
        begin
            if (!NRST)
            begin
                pend_q[g] <= 1'b0;
                kind_q[g] <= emr_pkg::EMR_KIND_SERR;
            end
            // A new edge wins over the entry being taken this cycle
            else if (rise[g] && (serr_ok || smi_enable_q[g] || sci_enable_q[g]))
            begin
                pend_q[g] <= 1'b1;
                // Exactly one kind, SERR before SMI before SCI
                // Only the ECC bits can pick SMI or SCI
                if (serr_ok)
                begin
                    kind_q[g] <= emr_pkg::EMR_KIND_SERR;
                end
                else if (smi_enable_q[g])
                begin
                    kind_q[g] <= emr_pkg::EMR_KIND_SMI;
                end
                else
                begin
                    kind_q[g] <= emr_pkg::EMR_KIND_SCI;
                end
            end
            else if (take[g])
            begin
                pend_q[g] <= 1'b0;
            end
        end
    end : g_flag

    // Output slot toward the hub link; held until MSG_READY
    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
        begin
            msg_q <= '{valid: 1'b0, kind: emr_pkg::EMR_KIND_SERR, source: 4'h0};
        end
        // Enabled flag edge becomes a message
        // Message packet is the only SERR path
        else if (load)
        begin
            msg_q.valid  <= 1'b1;
            msg_q.kind   <= kind_q[pick_idx];
            msg_q.source <= pick_idx;
        end
        else if (MSG_READY)
        begin
            msg_q.valid <= 1'b0;
        end
    end

endmodule // emr_router

// file: emr_router_asserts.sv
// Port checker for the error message router
`timescale 1ns/10ps
module emr_router_chk #(
    parameter int FLAG_W = 16  // Flag vector width
) (
    // Clock, reset, APB
    input wire logic              CLK_SYS, NRST, PSEL, PENABLE, PWRITE,
    input wire logic [11:0]       PADDR,
    input wire logic [31:0]       PWDATA, PRDATA,
    input wire logic              PREADY, PSLVERR,
    // Flags and hub link
    input wire logic [FLAG_W-1:0] ERR_FLAGS,
    input wire logic              PCI_SERR_EN, MSG_READY,
    input wire emr_pkg::emr_msg_t MSG
);
    logic rd;  // Read access phase
    logic map; // Address decodes to a register
    assign rd = PSEL && PENABLE && !PWRITE;
    // Byte lanes are ignored by the decode, so only the word index matters
    assign map = PADDR[11:2] inside {10'h0ca, 10'h0cc, 10'h0ce, 10'h0d0, 10'h0de};
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    a_rsv_serr: assert property (rd && PADDR == 12'h328 |-> (PRDATA & ~32'h027f) == 0)
        else $error("serr enable reserved bits read nonzero");
    a_rsv_smi: assert property (rd && PADDR == 12'h330 |-> PRDATA[31:2] == 0)
        else $error("smi enable reserved bits read nonzero");
    a_rsv_sci: assert property (rd && PADDR == 12'h338 |-> PRDATA[31:2] == 0)
        else $error("sci enable reserved bits read nonzero");
    a_unmapped_err: assert property (rd && !map |-> PSLVERR && PRDATA == 0)
        else $error("unmapped read not refused");
    a_serr_source: assert property (MSG.valid && MSG.kind == emr_pkg::EMR_KIND_SERR
        |-> MSG.source inside {[0:6], 9}) else $error("serr from reserved source");
    a_ecc_source: assert property (MSG.valid && MSG.kind != emr_pkg::EMR_KIND_SERR
        |-> MSG.source <= 1) else $error("smi or sci from non ecc source");
    a_msg_hold: assert property (MSG.valid && !MSG_READY |=> MSG.valid && $stable(MSG))
        else $error("message changed before acceptance");
    a_release_idle: assert property ($rose(NRST) |-> !MSG.valid)
        else $error("message valid right after reset");
    c_serr: cover property (MSG.valid && MSG_READY && MSG.kind == emr_pkg::EMR_KIND_SERR);
    c_smi: cover property (MSG.valid && MSG_READY && MSG.kind == emr_pkg::EMR_KIND_SMI);
    c_sci: cover property (MSG.valid && MSG_READY && MSG.kind == emr_pkg::EMR_KIND_SCI);
endmodule // emr_router_chk
bind emr_router emr_router_chk #(.FLAG_W(FLAG_W)) u_chk (.CLK_SYS(CLK_SYS), .NRST(NRST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .ERR_FLAGS(ERR_FLAGS),
    .PCI_SERR_EN(PCI_SERR_EN), .MSG_READY(MSG_READY), .MSG(MSG));

// file: emr_router_tb.sv
// Self-checking bench for the error message router
`timescale 1ns/10ps
`include "emr_cfg.svh"
module emr_router_tb;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, serr_en, ready, slow, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] flags, scr;
    emr_pkg::emr_msg_t msg;
    logic [5:0] expq[$]; // Expected kind and source, oldest first
    int errors, n_compared, cycles;
    // Byte address is four times the register index
    localparam logic [11:0] ADR[5] = '{12'h328, 12'h330, 12'h338, 12'h378, 12'h340};
    localparam logic [15:0] MSK[3] = '{`EMR_MASK_SERR_EN, `EMR_MASK_SMI_EN, `EMR_MASK_SCI_EN};
    localparam logic [3:0] SB[8] = '{0, 1, 2, 3, 4, 5, 6, 9};
    emr_router #(.FLAG_W(16)) DUT (.CLK_SYS(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .ERR_FLAGS(flags), .PCI_SERR_EN(serr_en), .MSG(msg), .MSG_READY(ready));
    emr_hub_link u_link (.CLK_SYS(clk), .NRST(nrst), .SLOW(slow), .MSG(msg), .MSG_READY(ready));
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Raise flags, wait for the queue to drain, hold to catch repeats, then drop
    task automatic fire(input logic [15:0] f);
        @(posedge clk);
        flags <= f;
        for (int i = 0; i < 80 && expq.size() != 0; i++)
            @(posedge clk);
        repeat (6)
            @(posedge clk);
        check(expq.size(), 0);
        flags <= 16'h0000;
    endtask
    // Every accepted message must match the oldest expectation
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            complete_run();
        end
        if (nrst === 1'b1 && msg.valid === 1'b1 && ready === 1'b1)
            check({26'h0, msg.kind, msg.source}, (expq.size() == 0) ? 32'hffffffff : {26'h0, expq.pop_front()});
    end
    initial
    begin
        {nrst, psel, penable, pwrite, serr_en, slow, paddr, pwdata, flags} = '0;
        errors = 0;
        n_compared = 0;
        cycles = 0;
        void'($urandom(32'h19e91fe9));
        repeat (10)
            @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b0, ADR[i], 32'h0);
            check(rd, 32'h0);
            if (i < 3)
            begin
                apb(1'b1, ADR[i], 32'hffffffff);
                apb(1'b0, ADR[i], 32'h0);
                check(rd, {16'h0, MSK[i]});
            end
        end
        scr = 16'($urandom());
        apb(1'b1, ADR[3], {16'hffff, scr});
        apb(1'b0, ADR[3], 32'h0);
        check(rd, {16'h0, scr});
        apb(1'b0, 12'h004, 32'h0);
        check({rd[30:0], err}, 32'h1);
        $display("register test done");
        // Only serr enabled per error; smi and sci are first cleared to zero
        apb(1'b1, ADR[1], 32'h0);
        apb(1'b1, ADR[2], 32'h0);
        serr_en <= 1'b1;
        foreach (SB[i])
        begin
            expq.push_back({emr_pkg::EMR_KIND_SERR, SB[i]});
            fire(16'h0001 << SB[i]);
        end
        fire(16'h0180);
        slow <= 1'b1;
        foreach (SB[i])
            expq.push_back({emr_pkg::EMR_KIND_SERR, SB[i]});
        fire(16'h027f);
        serr_en <= 1'b0;
        fire(16'h0040);
        $display("serr test done");
        apb(1'b1, ADR[0], 32'h0);
        for (int k = 1; k <= 2; k++)
        begin
            apb(1'b1, ADR[1], 32'(k));
            apb(1'b1, ADR[2], 32'(3 - k));
            expq.push_back({(k == 1) ? emr_pkg::EMR_KIND_SMI : emr_pkg::EMR_KIND_SCI, 4'h0});
            expq.push_back({(k == 1) ? emr_pkg::EMR_KIND_SCI : emr_pkg::EMR_KIND_SMI, 4'h1});
            fire(16'h0003);
        end
        apb(1'b1, ADR[1], 32'h0);
        apb(1'b1, ADR[2], 32'h0);
        fire(16'h0003);
        nrst <= 1'b0;
        repeat (2)
            @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, ADR[3], 32'h0);
        check(rd, 32'h0);
        $display("message test done");
        complete_run();
    end
endmodule // emr_router_tb
